// [core/tspm_cfg.svh]
// Named offsets, codes, field positions and reset values of the probe mux
`ifndef TSPM_CFG_SVH
`define TSPM_CFG_SVH
// ==========================================================================
// Command codes
`define TSPM_CMD_ANALOG   8'h19
`define TSPM_CMD_DIGITAL  8'h18
`define TSPM_CMD_RFLOAD   8'h11
// ==========================================================================
// Digital probe groups and selections
`define TSPM_GRP_RXDATA   8'h70
`define TSPM_GRP_RXERR    8'h73
`define TSPM_SEL_CARRIER  4'h8
`define TSPM_SEL_7        4'h7
`define TSPM_SEL_6        4'h6
`define TSPM_SEL_5        4'h5
`define TSPM_SEL_4        4'h4
`define TSPM_SEL_3        4'h3
`define TSPM_SEL_2        4'h2
`define TSPM_SEL_1        4'h1
`define TSPM_SEL_0        4'h0
`define TSPM_PIN_LAST     4'h3
`define TSPM_LEN_LIMIT    8'h1c
// ==========================================================================
// Analog selection codes
`define TSPM_ANA_DAC      8'h00
`define TSPM_ANA_Q_RAW    8'h01
`define TSPM_ANA_I_RAW    8'h02
`define TSPM_ANA_Q_FILT   8'h03
`define TSPM_ANA_I_FILT   8'h04
`define TSPM_ANA_THRESH   8'h05
`define TSPM_ANA_RAW_CORRELATION_F   8'h06
`define TSPM_ANA_RAW_CORRELATION_R   8'h07
`define TSPM_ANA_PSK      8'h09
`define TSPM_ANA_SUBC     8'h0a
// ==========================================================================
// Non-volatile memory layout
`define TSPM_NVM_TB_ADDR  8'h17
`define TSPM_TB_EN_BIT    7
`define TSPM_RF_NVM_BASE  8'h80
`define TSPM_RF_LAST      3'h7
`define TSPM_NVM_RESET    8'h00
// ==========================================================================
// Register word offsets and fields
`define TSPM_REG_CMD      4'h0
`define TSPM_REG_STATUS   4'h1
`define TSPM_REG_CTRL     4'h2
`define TSPM_REG_NVM_ADDR 4'h3
`define TSPM_REG_NVM_DATA 4'h4
`define TSPM_RF_WIN_BIT   3
`define TSPM_ST_BUSY      0
`define TSPM_ST_STATE_LSB 1
`define TSPM_ST_STATE_MSB 3
`define TSPM_ST_ANA_ACT   4
`define TSPM_ST_TB_EN     5
`define TSPM_ST_BIT_DET   6
`define TSPM_CT_BUSY_CLR  0
`define TSPM_CT_MULTI     1
`define TSPM_CT_MIN_LSB   8
`define TSPM_CT_MIN_MSB   15
`define TSPM_RF_DEFAULT   8'h00
`define TSPM_MIN_DEFAULT  8'h00
`endif

// [core/tspm_pkg.sv]
// Types shared by the probe mux and its memory
package tspm_pkg;
   // =======================================================================
   // Bus and signal carriers
   typedef struct packed {
      logic [3:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } tspm_avs_req_t;
   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } tspm_avs_rsp_t;
   typedef struct packed {
      logic       end_of_data;
      logic       data_valid;
      logic       rx_data;
      logic       rx_active;
      logic       rx_receiving;
      logic       rx_chain_reset;
      logic       bit_clock;
      logic       collision;
      logic       data_err;
      logic       proto_err;
      logic [7:0] frame_length_byte;
   } tspm_rx_sig_t;
   typedef struct packed {
      logic [7:0] dac_value;
      logic [7:0] q_raw;
      logic [7:0] i_raw;
      logic [7:0] q_filt;
      logic [7:0] i_filt;
      logic [7:0] filtered_correlation;
      logic [7:0] raw_correlation;
      logic [7:0] signal_strength;
      logic [7:0] phase_shift_sum;
      logic [7:0] subcarrier_sum;
      logic       start_bit;
   } tspm_ana_sig_t;
   typedef struct packed {
      logic [7:0] group;
      logic [3:0] sel;
   } tspm_pin_cfg_t;
   // =======================================================================
   // Command engine
   typedef enum logic [2:0] {
      TSPM_IDLE   = 3'b000,
      TSPM_ANA_P1 = 3'b001,
      TSPM_ANA_P2 = 3'b010,
      TSPM_DIG_GR = 3'b011,
      TSPM_DIG_PS = 3'b100,
      TSPM_RFLOAD = 3'b101
   } tspm_cmd_state_t;
   typedef struct packed {
      tspm_cmd_state_t     cmd_state;
      logic [7:0]          ana_sel_two;
      logic [7:0]          ana_sel_one;
      logic                ana_active;
      tspm_pin_cfg_t [3:0] pins;
      logic [7:0]          dig_group;
      logic                busy;
      logic                multi_frame_receive;
      logic [7:0]          min_level;
      logic [7:0]          nvm_addr;
      logic [7:0][7:0]     rf;
      logic [2:0]          rf_idx;
      logic                start_seen;
      logic                ack;
      logic [31:0]         readdata;
      logic [3:0]          dig_out;
      logic [7:0]          aux_one;
      logic [7:0]          aux_two;
      logic [1:0]          aux_en;
      logic                bit_detect;
   } tspm_state_t;
   typedef struct packed {
      logic [255:0][7:0] mem;
   } tspm_nvm_state_t;
endpackage : tspm_pkg

// [core/tspm_nvm.sv]
// Non-volatile byte store with one write port, one read port and a fixed read of the probe bus enable byte
`include "tspm_cfg.svh"
module tspm_nvm (
   input  wire logic       clk_i,     // Core clock
   input  wire logic       resetn_i,  // Async reset, active low
   input  wire logic       we_i,      // Write strobe
   input  wire logic [7:0] addr_i,    // Byte address
   input  wire logic [7:0] wdata_i,   // Write data
   output logic      [7:0] rdata_o,   // Read data at addr_i
   output logic      [7:0] tb_byte_o  // Probe bus enable byte
);
   import tspm_pkg::*;

   tspm_nvm_state_t s;
   tspm_nvm_state_t next_s;

   // Reset stands in for the stored image so simulation starts defined
   always_comb begin
      next_s = s;
      if (we_i) begin
         next_s.mem[addr_i] = wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rdata_o   = s.mem[addr_i];
   assign tb_byte_o = s.mem[`TSPM_NVM_TB_ADDR];
endmodule // tspm_nvm

// [core/tspm_probe_mux.sv]
// Command-driven probe multiplexer with register slave and settings load
`include "tspm_cfg.svh"
module tspm_probe_mux (
   input  wire logic                    CLK_I,         // Core clock 25 MHz
   input  wire logic                    RESETN_I,      // Async reset, low
   input  wire tspm_pkg::tspm_avs_req_t AVS_I,         // Avalon-MM request
   output tspm_pkg::tspm_avs_rsp_t      AVS_O,         // Avalon-MM answer
   input  wire tspm_pkg::tspm_rx_sig_t  RX_I,          // Receiver flags
   input  wire tspm_pkg::tspm_ana_sig_t ANA_I,         // Receiver samples
   input  wire logic                    CARRIER_I,     // Carrier clock
   output logic                  [3:0]  DIG_O,         // IRQ,AUXILIARY_PIN_ONE,AUXILIARY_PIN_TWO,GPO1
   output logic                  [7:0]  AUX_ONE_O,     // Analog on pin one
   output logic                  [7:0]  AUX_TWO_O,     // Analog on pin two
   output logic                  [1:0]  AUX_EN_O,      // Analog valid 1/2
   output logic                         BIT_DETECT_O,  // Bit detected
   output logic                  [7:0]  RF_REG_O [8]   // RF settings
);
   import tspm_pkg::*;

   // ========================================================================
   // Signal selection
   function automatic logic dig_select(
      input tspm_pin_cfg_t c,
      input tspm_rx_sig_t  r,
      input logic          long_frame,
      input logic          carrier
   );
      logic v;
      v = 1'b0;
      if (c.sel == `TSPM_SEL_CARRIER) begin
         v = carrier;
      end else if (c.group == `TSPM_GRP_RXDATA) begin
         unique case (c.sel)
            `TSPM_SEL_7: v = r.collision;
            `TSPM_SEL_6: v = r.end_of_data;
            `TSPM_SEL_5: v = r.data_valid;
            `TSPM_SEL_4: v = r.rx_data;
            `TSPM_SEL_3: v = r.rx_active;
            `TSPM_SEL_2: v = r.rx_receiving;
            `TSPM_SEL_1: v = r.rx_chain_reset;
            `TSPM_SEL_0: v = r.bit_clock;
            default:     v = 1'b0;
         endcase
      end else if (c.group == `TSPM_GRP_RXERR) begin
         unique case (c.sel)
            `TSPM_SEL_7: v = r.data_err | r.proto_err | r.collision;
            `TSPM_SEL_6: v = long_frame;
            `TSPM_SEL_2: v = r.collision;
            `TSPM_SEL_1: v = r.proto_err;
            `TSPM_SEL_0: v = r.data_err;
            default:     v = 1'b0;
         endcase
      end
      return v;
   endfunction

   function automatic logic [7:0] ana_select(
      input logic [7:0]    code,
      input tspm_ana_sig_t a,
      input logic [7:0]    thresh
   );
      logic [7:0] v;
      v = 8'h00;
      unique case (code)
         `TSPM_ANA_DAC:    v = a.dac_value;
         `TSPM_ANA_Q_RAW:  v = a.q_raw;
         `TSPM_ANA_I_RAW:  v = a.i_raw;
         `TSPM_ANA_Q_FILT: v = a.q_filt;
         `TSPM_ANA_I_FILT: v = a.i_filt;
         `TSPM_ANA_THRESH: v = thresh;
         `TSPM_ANA_RAW_CORRELATION_F: v = a.filtered_correlation;
         `TSPM_ANA_RAW_CORRELATION_R: v = a.raw_correlation;
         `TSPM_ANA_PSK:    v = a.phase_shift_sum;
         `TSPM_ANA_SUBC:   v = a.subcarrier_sum;
         default:          v = 8'h00;
      endcase
      return v;
   endfunction

   // ========================================================================
   // State and memory
   tspm_state_t s;
   tspm_state_t next_s;
   logic        nvm_we;
   logic [7:0]  nvm_addr;
   logic [7:0]  nvm_rdata;
   logic [7:0]  tb_byte;
   logic        tb_en;
   logic        req;
   logic        hold;
   logic        cmd_wr;
   logic [7:0]  cmd_byte;
   logic [7:0]  thresh;
   logic        long_frame;
   logic [3:0]  dig_sel;
   logic        copying;

   tspm_nvm u_nvm (
      .clk_i     (CLK_I),
      .resetn_i  (RESETN_I),
      .we_i      (nvm_we),
      .addr_i    (nvm_addr),
      .wdata_i   (AVS_I.writedata[7:0]),
      .rdata_o   (nvm_rdata),
      .tb_byte_o (tb_byte)
   );

   assign tb_en   = tb_byte[`TSPM_TB_EN_BIT];
   assign copying = (s.cmd_state == TSPM_RFLOAD);
   assign nvm_addr = copying ?
                     (`TSPM_RF_NVM_BASE + {5'h00, s.rf_idx}) : s.nvm_addr;

   // ========================================================================
   // Bus handshake
   // Command and memory accesses wait out a running copy so bytes are
   // never dropped and the memory port is never shared.
   assign req  = AVS_I.read | AVS_I.write;
   assign hold = copying &&
                 (AVS_I.address == `TSPM_REG_CMD ||
                  AVS_I.address == `TSPM_REG_NVM_DATA);
   assign cmd_wr = AVS_I.write && s.ack &&
                   AVS_I.address == `TSPM_REG_CMD;
   assign cmd_byte = AVS_I.writedata[7:0];
   assign nvm_we = AVS_I.write && s.ack &&
                   AVS_I.address == `TSPM_REG_NVM_DATA;

   // ========================================================================
   // Receiver threshold
   assign thresh = s.start_seen ? {1'b0, ANA_I.signal_strength[7:1]}
                                : s.min_level;
   assign long_frame = s.multi_frame_receive &&
                       (RX_I.frame_length_byte > `TSPM_LEN_LIMIT);

   generate
      for (genvar p = 0; p < 4; p++) begin : g_pin
         assign dig_sel[p] = dig_select(s.pins[p], RX_I, long_frame,
                                        CARRIER_I);
      end
   endgenerate

   always_comb begin
      next_s     = s;
      next_s.ack = req && !s.ack && !hold;
      // Read data is taken in the stall cycle and stands at the answer
      if (AVS_I.read && !s.ack && !hold) begin
         next_s.readdata = 32'h0000_0000;
         if (AVS_I.address[`TSPM_RF_WIN_BIT]) begin
            next_s.readdata[7:0] = s.rf[AVS_I.address[2:0]];
         end else begin
            unique case (AVS_I.address)
               `TSPM_REG_STATUS: begin
                  next_s.readdata[`TSPM_ST_BUSY] = s.busy;
                  next_s.readdata[`TSPM_ST_STATE_MSB:`TSPM_ST_STATE_LSB] =
                     s.cmd_state;
                  next_s.readdata[`TSPM_ST_ANA_ACT] = s.ana_active;
                  next_s.readdata[`TSPM_ST_TB_EN]   = tb_en;
                  next_s.readdata[`TSPM_ST_BIT_DET] = s.bit_detect;
               end
               `TSPM_REG_CTRL: begin
                  next_s.readdata[`TSPM_CT_MULTI] = s.multi_frame_receive;
                  next_s.readdata[`TSPM_CT_MIN_MSB:`TSPM_CT_MIN_LSB] =
                     s.min_level;
               end
               `TSPM_REG_NVM_ADDR: next_s.readdata[7:0] = s.nvm_addr;
               `TSPM_REG_NVM_DATA: next_s.readdata[7:0] = nvm_rdata;
               default:            next_s.readdata = 32'h0000_0000;
            endcase
         end
      end
      // Register writes take effect at the edge that ends the access, one edge after the wait ends
      if (AVS_I.write && s.ack) begin
         unique case (AVS_I.address)
            `TSPM_REG_CTRL: begin
               if (AVS_I.writedata[`TSPM_CT_BUSY_CLR]) begin
                  next_s.busy = 1'b0;
               end
               next_s.multi_frame_receive =
                  AVS_I.writedata[`TSPM_CT_MULTI];
               next_s.min_level =
                  AVS_I.writedata[`TSPM_CT_MIN_MSB:`TSPM_CT_MIN_LSB];
            end
            `TSPM_REG_NVM_ADDR: next_s.nvm_addr = AVS_I.writedata[7:0];
            default: ;
         endcase
      end
      // Command engine; a completion setting busy wins over a clear
      unique case (s.cmd_state)
         TSPM_IDLE: begin
            if (cmd_wr) begin
               if (cmd_byte == `TSPM_CMD_ANALOG) begin
                  next_s.busy      = 1'b0;
                  next_s.cmd_state = TSPM_ANA_P1;
               end else if (cmd_byte == `TSPM_CMD_DIGITAL) begin
                  next_s.busy      = 1'b0;
                  next_s.cmd_state = TSPM_DIG_GR;
               end else if (cmd_byte == `TSPM_CMD_RFLOAD) begin
                  next_s.busy      = 1'b0;
                  next_s.rf_idx    = 3'h0;
                  next_s.cmd_state = TSPM_RFLOAD;
               end
            end
         end
         TSPM_ANA_P1: begin
            if (cmd_wr) begin
               next_s.ana_sel_two = cmd_byte;
               next_s.cmd_state   = TSPM_ANA_P2;
            end
         end
         TSPM_ANA_P2: begin
            if (cmd_wr) begin
               next_s.ana_sel_one = cmd_byte;
               next_s.ana_active  = 1'b1;
               next_s.busy        = 1'b1;
               next_s.cmd_state   = TSPM_IDLE;
            end
         end
         TSPM_DIG_GR: begin
            if (cmd_wr) begin
               next_s.dig_group = cmd_byte;
               next_s.cmd_state = TSPM_DIG_PS;
            end
         end
         TSPM_DIG_PS: begin
            if (cmd_wr) begin
               // Only the addressed pin changes; others keep theirs
               if (cmd_byte[7:4] <= `TSPM_PIN_LAST) begin
                  next_s.pins[cmd_byte[5:4]].group = s.dig_group;
                  next_s.pins[cmd_byte[5:4]].sel   = cmd_byte[3:0];
               end
               next_s.busy      = 1'b1;
               next_s.cmd_state = TSPM_IDLE;
            end
         end
         TSPM_RFLOAD: begin
            next_s.rf[s.rf_idx] = nvm_rdata;
            next_s.rf_idx       = s.rf_idx + 3'h1;
            if (s.rf_idx == `TSPM_RF_LAST) begin
               next_s.busy      = 1'b1;
               next_s.cmd_state = TSPM_IDLE;
            end
         end
         default: next_s.cmd_state = TSPM_IDLE;
      endcase
      // Threshold tracking; a start bit wins over a chain reset
      if (ANA_I.start_bit) begin
         next_s.start_seen = 1'b1;
      end else if (RX_I.rx_chain_reset) begin
         next_s.start_seen = 1'b0;
      end
      next_s.bit_detect = ANA_I.filtered_correlation > thresh;
      // Probe outputs are registered, so the carrier is resampled at core rate
      next_s.dig_out = tb_en ? dig_sel : 4'h0;
      if (tb_en && s.ana_active) begin
         next_s.aux_two = ana_select(s.ana_sel_two, ANA_I, thresh);
         next_s.aux_one = ana_select(s.ana_sel_one, ANA_I, thresh);
         next_s.aux_en  = 2'b11;
      end else begin
         next_s.aux_two = 8'h00;
         next_s.aux_one = 8'h00;
         next_s.aux_en  = 2'b00;
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         s           <= '0;
         s.cmd_state <= TSPM_IDLE;
         s.rf        <= {8{`TSPM_RF_DEFAULT}};
         s.min_level <= `TSPM_MIN_DEFAULT;
      end else begin
         s <= next_s;
      end
   end

   // ========================================================================
   // Outputs
   assign AVS_O.readdata    = s.readdata;
   assign AVS_O.waitrequest = req && !s.ack;
   assign DIG_O             = s.dig_out;
   assign AUX_ONE_O         = s.aux_one;
   assign AUX_TWO_O         = s.aux_two;
   assign AUX_EN_O          = s.aux_en;
   assign BIT_DETECT_O      = s.bit_detect;

   generate
      for (genvar r = 0; r < 8; r++) begin : g_rf
         assign RF_REG_O[r] = s.rf[r];
      end
   endgenerate
endmodule // tspm_probe_mux

// [testbench/tspm_probe_mux_asserts.sv]
// Port checker of the probe mux, bound to its top module
module tspm_probe_mux_asserts (
   input wire logic                    CLK_I,        // Clock
   input wire logic                    RESETN_I,     // Reset, low
   input wire tspm_pkg::tspm_avs_req_t AVS_I,        // Request
   input wire tspm_pkg::tspm_avs_rsp_t AVS_O,        // Answer
   input wire tspm_pkg::tspm_ana_sig_t ANA_I,        // Samples
   input wire logic [3:0]              DIG_O,        // Probes
   input wire logic [1:0]              AUX_EN_O,     // Analog valid
   input wire logic                    BIT_DETECT_O, // Bit found
   input wire logic [7:0]              RF_REG_O [8]  // RF settings
);
   timeunit 1ns;
   timeprecision 1ns;
   import tspm_pkg::*;
   logic [3:0] since_wr;
   logic       req;
   assign req = AVS_I.read || AVS_I.write;
   // ==========
   // Age of the last write; output changes need a recent cause
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I)
         since_wr <= 4'hf;
      else if (AVS_I.write && !AVS_O.waitrequest)
         since_wr <= 4'h0;
      else if (since_wr != 4'hf)
         since_wr <= since_wr + 4'h1;
   end
   default clocking @(posedge CLK_I);
   endclocking
   default disable iff (!RESETN_I);
   // ==========
   // Properties
   property p_rst; $past(!RESETN_I) |-> {DIG_O, AUX_EN_O} == 6'h0; endproperty
   a_rst: assert property (p_rst) else $error("probe live at reset");
   property p_pair; AUX_EN_O == 2'h0 || AUX_EN_O == 2'h3; endproperty
   a_pair: assert property (p_pair) else $error("aux enables split");
   property p_aux; $changed(AUX_EN_O) |-> since_wr < 4'h4; endproperty
   a_aux: assert property (p_aux) else $error("aux moved uncaused");
   property p_rf; $changed(RF_REG_O[7]) |-> since_wr < 4'hc; endproperty
   a_rf: assert property (p_rf) else $error("rf moved uncaused");
   property p_bit;
      BIT_DETECT_O |-> $past(ANA_I.filtered_correlation) != 8'h00;
   endproperty
   a_bit: assert property (p_bit) else $error("bit on zero level");
   property p_first; req && !$past(req) |-> AVS_O.waitrequest; endproperty
   a_first: assert property (p_first) else $error("no wait cycle");
   property p_once; req && !AVS_O.waitrequest |-> $past(AVS_O.waitrequest);
   endproperty
   a_once: assert property (p_once) else $error("answer too soon");
   property p_unmap;
      AVS_I.read && !AVS_O.waitrequest && AVS_I.address inside {[4'h5:4'h7]}
         |-> AVS_O.readdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped not 0");
endmodule // tspm_probe_mux_asserts
bind tspm_probe_mux tspm_probe_mux_asserts tspm_probe_mux_asserts_i (
   .CLK_I(CLK_I), .RESETN_I(RESETN_I), .AVS_I(AVS_I), .AVS_O(AVS_O),
   .ANA_I(ANA_I), .DIG_O(DIG_O), .AUX_EN_O(AUX_EN_O),
   .BIT_DETECT_O(BIT_DETECT_O), .RF_REG_O(RF_REG_O));

// [testbench/tspm_host.sv]
// Host model: Avalon-MM master that sends probe commands
module tspm_host (
   input  wire logic                    clk_i, // Clock
   input  wire tspm_pkg::tspm_avs_rsp_t rsp_i, // Slave answer
   output tspm_pkg::tspm_avs_req_t      req_o  // Request
);
   timeunit 1ns;
   timeprecision 1ns;
   import tspm_pkg::*;
   initial req_o = '0;
   // ==========
   // One access, held until waitrequest is sampled low or 40 samples pass
   task automatic xfer(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic ok);
      int n;
      @(posedge clk_i);
      req_o.address <= a;
      req_o.read <= !w;
      req_o.write <= w;
      req_o.writedata <= d;
      ok = 1'b0;
      // Look between edges so the answering edge is never raced
      for (n = 0; n < 40 && !ok; n++) begin
         @(negedge clk_i);
         ok = rsp_i.waitrequest === 1'b0;
         q = rsp_i.readdata;
         @(posedge clk_i);
      end
      req_o.read <= 1'b0;
      req_o.write <= 1'b0;
   endtask
   // Command bytes first to last, then busy must rise before going on
   task automatic cmd(input int n, input logic [23:0] b, output logic ok);
      logic [31:0] q;
      logic        k;
      int          i;
      ok = 1'b1;
      for (i = n - 1; i >= 0; i--) begin
         xfer(1'b1, 4'h0, {24'h0, b[i*8 +: 8]}, q, k);
         ok = ok & k;
      end
      q = '0;
      for (i = 0; i < 20 && q[0] !== 1'b1; i++)
         xfer(1'b0, 4'h1, 32'h0, q, k);
      ok = ok & (q[0] === 1'b1);
   endtask
endmodule // tspm_host

// [testbench/tspm_probe_mux_tb.sv]
// Self-checking bench of the probe mux with a host model
module tspm_probe_mux_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import tspm_pkg::*;
   logic          clk;
   logic          resetn;
   tspm_avs_req_t avs_req;
   tspm_avs_rsp_t avs_rsp;
   tspm_rx_sig_t  rx;
   tspm_ana_sig_t ana;
   logic          carrier;
   logic [3:0]    dig;
   logic [7:0]    aux_one;
   logic [7:0]    aux_two;
   logic [1:0]    aux_en;
   logic          bit_det;
   logic [7:0]    rf_reg [8];
   logic [31:0]   q;
   logic          k;
   int            fails;
   int            cmp_count;
   // Error group table: select, expected pin level, receiver flags
   localparam logic [27:0] ERR_T [12] = '{28'h0100200, 28'h003fdff,
      28'h1100100, 28'h103feff, 28'h2100400, 28'h203fbff, 28'h303ffff,
      28'h403ffff, 28'h503ffff, 28'h7100200, 28'h7100400, 28'h703f8ff};
   tspm_probe_mux tspm_probe_mux_i (.CLK_I(clk), .RESETN_I(resetn),
      .AVS_I(avs_req), .AVS_O(avs_rsp), .RX_I(rx), .ANA_I(ana),
      .CARRIER_I(carrier), .DIG_O(dig), .AUX_ONE_O(aux_one),
      .AUX_TWO_O(aux_two), .AUX_EN_O(aux_en), .BIT_DETECT_O(bit_det),
      .RF_REG_O(rf_reg));
   tspm_host tspm_host_i (.clk_i(clk), .rsp_i(avs_rsp), .req_o(avs_req));
   // ==========
   // Shared tasks
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e, string m);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask
   // A lost answer ends the run, nothing after it can be trusted
   task automatic bus_ok;
      cmp(k, 1'b1, "no answer");
      if (k !== 1'b1)
         finish_test();
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      tspm_host_i.xfer(1'b1, a, d, q, k);
      bus_ok();
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, string m);
      tspm_host_i.xfer(1'b0, a, 32'h0, q, k);
      bus_ok();
      cmp(q, e, m);
   endtask
   task automatic cmd(input int n, input logic [23:0] b);
      tspm_host_i.cmd(n, b, k);
      bus_ok();
   endtask
   task automatic nvm(input logic [7:0] a, input logic [7:0] d);
      wr(4'h3, {24'h0, a});
      wr(4'h4, {24'h0, d});
   endtask
   task automatic settle;
      repeat (3) @(posedge clk);
   endtask
   task automatic see(input logic [17:0] v, input int p, input logic e);
      @(posedge clk);
      rx <= tspm_rx_sig_t'(v);
      settle();
      cmp(dig[p], e, "digital probe");
   endtask
   task automatic bd(input logic [7:0] c, input logic s, input logic e);
      @(posedge clk);
      ana.filtered_correlation <= c;
      ana.start_bit <= s;
      settle();
      cmp(bit_det, e, "bit detect");
   endtask
   function automatic logic [7:0] ana_exp(input logic [7:0] c);
      if (c == 8'h05)
         return 8'h55;
      if (c == 8'h08 || c > 8'h0a)
         return 8'h00;
      return 8'ha0 + c;
   endfunction
   // ==========
   // Scenarios
   task automatic s_reset;
      int i;
      cmp({dig, aux_en, bit_det}, 7'h0, "reset outputs");
      for (i = 0; i < 8; i++)
         cmp(rf_reg[i], 8'h00, "rf default");
      wr(4'h5, 32'h5a);
      rd(4'h5, 32'h0, "unmapped");
      rd(4'h8, 32'h0, "rf read");
   endtask
   task automatic s_enable;
      nvm(8'h17, 8'h7f);
      cmd(3, 24'h190102);
      cmd(3, 24'h187010);
      see(18'h3ffff, 1, 1'b0);
      cmp(aux_en, 2'h0, "analog off");
      nvm(8'h17, 8'h80);
      see(18'h3ffff, 1, 1'b1);
      cmp(aux_en, 2'h3, "analog on");
   endtask
   task automatic s_analog;
      int c;
      wr(4'h2, 32'h5500);
      @(posedge clk);
      ana <= tspm_ana_sig_t'({80'ha0a1a2a3a4a6a720a9aa, 1'b0});
      for (c = 0; c < 12; c++) begin
         cmd(3, {8'h19, c[7:0], 8'h0b - c[7:0]});
         settle();
         cmp(aux_two, ana_exp(c[7:0]), "aux two");
         cmp(aux_one, ana_exp(8'h0b - c[7:0]), "aux one");
      end
   endtask
   task automatic s_digital;
      int i;
      for (i = 0; i < 7; i++) begin
         cmd(3, {16'h1870, 8'h10 + i[7:0]});
         see(18'h00800 << i, 1, 1'b1);
         see(18'h3ffff ^ (18'h00800 << i), 1, 1'b0);
      end
      for (i = 0; i < 12; i++) begin
         cmd(3, {16'h1873, 4'h2, ERR_T[i][27:24]});
         see(ERR_T[i][17:0], 2, ERR_T[i][20]);
      end
      cmp(dig[1], 1'b1, "pin one kept");
      cmd(3, 24'h187338);
      for (i = 1; i >= 0; i--) begin
         @(posedge clk);
         carrier <= i[0];
         settle();
         cmp(dig[3], i[0], "carrier");
      end
   endtask
   task automatic s_frame;
      cmd(3, 24'h187326);
      see(18'h0001d, 2, 1'b0);
      wr(4'h2, 32'h5502);
      see(18'h0001d, 2, 1'b1);
      see(18'h0001c, 2, 1'b0);
   endtask
   task automatic s_thresh;
      bd(8'h55, 1'b0, 1'b0);
      bd(8'h56, 1'b0, 1'b1);
      bd(8'h11, 1'b1, 1'b1);
      bd(8'h10, 1'b0, 1'b0);
      cmd(3, 24'h190505);
      settle();
      cmp(aux_two, 8'h10, "half strength");
   endtask
   task automatic s_rfload;
      int i;
      for (i = 0; i < 8; i++)
         nvm(8'h80 + i[7:0], 8'hc0 + i[7:0]);
      cmd(1, 24'h11);
      settle();
      for (i = 0; i < 8; i++)
         cmp(rf_reg[i], 8'hc0 + i[7:0], "rf copy");
      rd(4'hf, 32'hc7, "rf read");
   endtask
   task automatic s_rerun;
      @(posedge clk);
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      settle();
      cmp({dig, aux_en, rf_reg[0]}, 14'h0, "after reset");
   endtask
   // ==========
   // Clock and main sequence
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      resetn = 1'b0;
      rx = '0;
      ana = '0;
      carrier = 1'b0;
      fails = 0;
      cmp_count = 0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      s_reset();
      s_enable();
      s_analog();
      s_digital();
      s_frame();
      s_thresh();
      s_rfload();
      s_rerun();
      finish_test();
   end
endmodule // tspm_probe_mux_tb
